/* File: bench/serial_gpio_link_initiator_bench.sv */
// Self-checking bench for the serial expander link initiator
`timescale 1ns/10ps
module serial_gpio_link_initiator_bench;
   localparam HALF = 8;
   reg core_clk_i, resetn_i, alert_bus_i, alert_sysif_i, rdy0, rdy1, irq_n, stall;
   reg [15:0] w0, w1;
   reg [31:0] tx;
   wire [31:0] held, sent;
   wire [15:0] q0, q1, fr;
   wire v0, v1, drop, sclk, ld0, ld1, do0, do1, rstl, di0, di1, seen;
   integer err_count, check_count, drops, i;
   reg [15:0] exp0[$];
   reg [15:0] exp1[$];
   sgl_initiator #(.HALF(HALF)) u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .chan0_out_word_i(w0),
      .chan1_out_word_i(w1), .alert_bus_i(alert_bus_i), .alert_sysif_i(alert_sysif_i), .chan0_in_word_o(q0),
      .chan0_in_valid_o(v0), .chan0_in_ready_i(rdy0), .chan1_in_word_o(q1), .chan1_in_valid_o(v1),
      .chan1_in_ready_i(rdy1), .irq_seen_o(seen), .frame_drop_o(drop), .serial_expander_clock_o(sclk),
      .chan0_load_strobe_o(ld0), .chan1_load_strobe_o(ld1), .chan0_out_data_o(do0), .chan1_out_data_o(do1),
      .expander_reset_low_o(rstl), .chan0_in_data_i(di0), .chan1_in_data_i(di1), .responder_irq_low_i(irq_n));
   sgl_responder u_resp (.serial_expander_clock_i(sclk), .chan0_load_strobe_i(ld0), .chan0_out_data_i(do0),
      .chan1_out_data_i(do1), .expander_reset_low_i(rstl), .tx_i(tx), .chan0_in_data_o(di0),
      .chan1_in_data_o(di1), .held_o(held), .sent_o(sent), .fr_o(fr));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task chk(input [15:0] got, input [15:0] want, input string nm);
      begin
         check_count = check_count + 1;
         if (got !== want) begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, want, got);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // Reset holds 5 cycles; first frame after release must carry safe words
   task do_reset;
      begin
         resetn_i = 1'b0;
         {alert_bus_i, alert_sysif_i} = 2'b00;
         repeat (5) @(negedge core_clk_i);
         chk({15'h0000, rstl}, 16'h0000, "link reset");
         exp0.delete();
         exp1.delete();
         resetn_i = 1'b1;
         @(fr);
         chk(held[31:16], 16'h0000, "safe word 0");
         chk(held[15:0], 16'h0000, "safe word 1");
         // Inbound bits of the safe frame are never delivered, so drop that note
         #1;
         exp0.delete();
         exp1.delete();
      end
   endtask
   // Responder finished a frame: note what it sent
   always @(fr) begin
      if (fr !== 16'h0000) begin
         exp0.push_back(sent[31:16]);
         exp1.push_back(sent[15:0]);
      end
   end
   // Consumer ready is random, or held low to fill the buffers
   always @(negedge core_clk_i) begin
      rdy0 <= !stall && $urandom_range(0, 1);
      rdy1 <= !stall && $urandom_range(0, 1);
   end
   // A dropped frame is the newest note; taken words meet the oldest
   always @(posedge core_clk_i) begin
      if (drop === 1'b1) begin
         drops = drops + 1;
         void'(exp0.pop_back());
         void'(exp1.pop_back());
      end
      if (v0 === 1'b1 && rdy0 === 1'b1) chk(q0, exp0.pop_front(), "chan0 in word");
      if (v1 === 1'b1 && rdy1 === 1'b1) chk(q1, exp1.pop_front(), "chan1 in word");
   end
   // The run takes some 40 frames of 2.56 us; four times that is a hang
   initial begin
      #400000;
      err_count = err_count + 1;
      summarize;
   end
   initial begin
      void'($urandom(13533));
      err_count = 0;
      check_count = 0;
      drops = 0;
      // Consumer free to take words, interrupt line idle high
      {stall, irq_n, rdy0, rdy1} = 4'h4;
      {w0, w1, tx} = {$urandom, $urandom};
      do_reset;
      for (i = 0; i < 6; i = i + 1) begin
         @(negedge core_clk_i);
         {w0, w1, tx} = {$urandom, $urandom};
         {alert_bus_i, alert_sysif_i} = i[1:0];
         repeat (3) @(fr);
         chk(held[31:16], {alert_sysif_i, alert_bus_i, w0[13:0]}, "chan0 out word");
         chk(held[15:0], w1, "chan1 out word");
      end
      stall = 1'b1;
      repeat (12) @(fr);
      chk({15'h0000, drops != 0}, 16'h0001, "frame drop");
      stall = 1'b0;
      repeat (3) @(fr);
      @(negedge core_clk_i);
      irq_n = 1'b0;
      repeat (5) @(negedge core_clk_i);
      chk({15'h0000, seen}, 16'h0001, "irq seen");
      irq_n = 1'b1;
      repeat (5) @(negedge core_clk_i);
      chk({15'h0000, seen}, 16'h0000, "irq idle");
      do_reset;
      repeat (2) @(fr);
      summarize;
   end
endmodule
bind sgl_initiator sgl_props #(.NBITS(NBITS), .HALF(HALF)) u_props (.core_clk_i, .resetn_i, .serial_expander_clock_o,
   .chan0_load_strobe_o, .chan1_load_strobe_o, .chan0_out_data_o, .expander_reset_low_o, .responder_irq_low_i,
   .irq_seen_o);

/* File: bench/sgl_props.sv */
// Checker watching the link initiator pins
`timescale 1ns/10ps
module sgl_props #(
   parameter NBITS = 16,
   parameter HALF = 2
) (
   input wire core_clk_i,
   input wire resetn_i,
   input wire serial_expander_clock_o,
   input wire chan0_load_strobe_o,
   input wire chan1_load_strobe_o,
   input wire chan0_out_data_o,
   input wire expander_reset_low_o,
   input wire responder_irq_low_i,
   input wire irq_seen_o
);
   reg clk_q, stb_q;
   reg [7:0] tg_cnt, st_cnt;
   reg [15:0] fr_cnt;
   // Cycles since last clock toggle, since last strobe rise, and of strobe high time
   always @(posedge core_clk_i) begin
      clk_q <= serial_expander_clock_o;
      stb_q <= chan0_load_strobe_o;
      st_cnt <= chan0_load_strobe_o ? st_cnt + 8'h01 : 8'h00;
      if (!resetn_i) begin
         tg_cnt <= 8'h00;
         fr_cnt <= 16'h0000;
      end else begin
         // Counters wait at zero until the first event, so no stale span is judged
         tg_cnt <= (serial_expander_clock_o != clk_q) ? 8'h01 : tg_cnt + {7'h00, tg_cnt != 8'h00};
         fr_cnt <= (chan0_load_strobe_o && !stb_q) ? 16'h0001 : fr_cnt + {15'h0000, fr_cnt != 16'h0000};
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   sequence s_irq_low;
      !responder_irq_low_i [*4];
   endsequence
   sequence s_irq_high;
      responder_irq_low_i [*4];
   endsequence
   property p_half;
      disable iff (!resetn_i) (serial_expander_clock_o != clk_q) && tg_cnt != 8'h00 |-> tg_cnt == HALF;
   endproperty
   a_half: assert property (p_half) else $error("serial clock half period wrong");
   property p_pair;
      disable iff (!resetn_i) chan0_load_strobe_o == chan1_load_strobe_o;
   endproperty
   a_pair: assert property (p_pair) else $error("channel strobes differ");
   property p_stb_edge;
      disable iff (!resetn_i) $rose(chan0_load_strobe_o) |-> $fell(serial_expander_clock_o) || $rose(expander_reset_low_o);
   endproperty
   a_stb_edge: assert property (p_stb_edge) else $error("strobe rose off a clock fall");
   property p_do_edge;
      disable iff (!resetn_i) $changed(chan0_out_data_o) |-> $fell(serial_expander_clock_o) || $rose(expander_reset_low_o);
   endproperty
   a_do_edge: assert property (p_do_edge) else $error("data changed off a clock fall");
   property p_stb_len;
      disable iff (!resetn_i) $fell(chan0_load_strobe_o) |-> st_cnt == 2 * HALF;
   endproperty
   a_stb_len: assert property (p_stb_len) else $error("strobe width wrong");
   property p_frame;
      disable iff (!resetn_i) $rose(chan0_load_strobe_o) && fr_cnt != 16'h0000 |-> fr_cnt == NBITS * 2 * HALF;
   endproperty
   a_frame: assert property (p_frame) else $error("frame spacing wrong");
   property p_rst;
      !resetn_i |=> !expander_reset_low_o && !serial_expander_clock_o && !chan0_load_strobe_o;
   endproperty
   a_rst: assert property (p_rst) else $error("link not held in reset");
   property p_rst_hold;
      disable iff (!resetn_i) expander_reset_low_o |=> expander_reset_low_o;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("link reset pulsed in run");
   property p_irq_on;
      disable iff (!resetn_i) s_irq_low |-> irq_seen_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not seen");
   property p_irq_off;
      disable iff (!resetn_i) s_irq_high |-> !irq_seen_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt seen while idle");
endmodule

/* File: bench/sgl_responder.sv */
// Responder model of the host module logic
`timescale 1ns/10ps
module sgl_responder (
   input wire serial_expander_clock_i,
   input wire chan0_load_strobe_i,
   input wire chan0_out_data_i,
   input wire chan1_out_data_i,
   input wire expander_reset_low_i,
   input wire [31:0] tx_i,
   output reg chan0_in_data_o,
   output reg chan1_in_data_o,
   output reg [31:0] held_o,
   output reg [31:0] sent_o,
   output reg [15:0] fr_o
);
   reg [15:0] sh0, sh1, tx0, tx1;
   reg [31:0] word; // Word loaded at the last strobe, kept unshifted
   reg live;
   // Input pins rest at their pull-up level until the first load
   initial begin
      fr_o = 16'h0000;
      {chan0_in_data_o, chan1_in_data_o} = 2'b11;
   end
   // Link reset clears both channels' latches and holding words
   always @(negedge expander_reset_low_i) begin
      {live, sh0, sh1, held_o} = 65'h0;
      {chan0_in_data_o, chan1_in_data_o} = 2'b11;
   end
   // Strobe marks the frame boundary: latch outputs, report, reload inputs
   always @(posedge chan0_load_strobe_i) begin
      #1;
      held_o = {sh0, sh1};
      if (live) begin
         sent_o = word;
         fr_o = fr_o + 16'h0001;
      end
      word = tx_i;
      {tx0, tx1} = tx_i;
      {chan0_in_data_o, chan1_in_data_o} = {tx0[15], tx1[15]};
      live = 1'b1;
   end
   // One clock times both channels; the 1 ns lag keeps us clear of the strobe update
   always @(negedge serial_expander_clock_i) begin
      #1;
      if (!chan0_load_strobe_i) begin
         {tx0, tx1} = {tx0[14:0], 1'b0, tx1[14:0], 1'b0};
         {chan0_in_data_o, chan1_in_data_o} = {tx0[15], tx1[15]};
      end
   end
   // Output bits are sampled on the rise, away from the launch edge
   always @(posedge serial_expander_clock_i) begin
      {sh0, sh1} = {sh0[14:0], chan0_out_data_i, sh1[14:0], chan1_out_data_i};
   end
endmodule

/* File: verilog/sgl_consts.vh */
// Constants for the serial expander link initiator
`ifndef SGL_CONSTS_VH
`define SGL_CONSTS_VH
// Core clock period in ps (100 MHz)
`define SGL_CORE_PERIOD_PS 10000
// Serial clock half period in core cycles: 100 MHz / (2*2) = 25 MHz, inside 20-37 MHz
`define SGL_CLK_HALF_CYC 2
// Default frame length in bits per channel
`define SGL_FRAME_BITS 16
// Frames of safe defaults sent after reset release
`define SGL_SAFE_FRAMES 1
// FIFO depth and address width
`define SGL_FIFO_DEPTH 8
`define SGL_FIFO_AW 3
`endif

/* File: verilog/sgl_fifo.v */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sgl_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire core_clk_i,
   input wire resetn_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // Storage words
   reg [AW-1:0] wr_ptr_ff; // Write index
   reg [AW-1:0] rd_ptr_ff; // Read index
   reg [AW:0] count_ff; // Fill level
   wire do_wr;
   wire do_rd;
   assign in_ready_o = (count_ff != DEPTH[AW:0]);
   assign out_valid_o = (count_ff != {(AW+1){1'b0}});
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign do_wr = in_valid_i & in_ready_o;
   assign do_rd = out_valid_o & out_ready_i;
   // Wrap an index at the depth
   function [AW-1:0] bump;
      input [AW-1:0] p;
      begin
         bump = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
      end
   endfunction
   // Pointer and level update
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_ff <= bump(wr_ptr_ff);
         end
         if (do_rd) begin
            rd_ptr_ff <= bump(rd_ptr_ff);
         end
         if (do_wr && !do_rd) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
   // Data write, no reset needed on storage
   always @(posedge core_clk_i) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end
endmodule

/* File: verilog/sgl_initiator.v */
// Serial expander link initiator: two channels on one shared serial clock
`timescale 1ns/10ps
`include "sgl_consts.vh"
// Summary of operation
// - We always make serial clock and load strobes
// - Two independent channels, each with own data
// - One serial clock shared by both channels
// - Output data driven synchronous to serial clock
// - One active-low reset common to both channels
// - Serial clock runs within 20 to 37 MHz only at the default HALF of 2 (25 MHz)
// - Bus alerts may ride as link bits
// - Management channel alert may ride as bit
module sgl_initiator #(
   parameter NBITS = `SGL_FRAME_BITS,
   parameter HALF = `SGL_CLK_HALF_CYC,
   parameter SAFE_FRAMES = `SGL_SAFE_FRAMES,
   parameter [NBITS-1:0] SAFE0 = {NBITS{1'b0}},
   parameter [NBITS-1:0] SAFE1 = {NBITS{1'b0}}
) (
   input wire core_clk_i,
   input wire resetn_i,
   input wire [NBITS-1:0] chan0_out_word_i,
   input wire [NBITS-1:0] chan1_out_word_i,
   input wire alert_bus_i,
   input wire alert_sysif_i,
   output reg [NBITS-1:0] chan0_in_word_o,
   output reg chan0_in_valid_o,
   input wire chan0_in_ready_i,
   output reg [NBITS-1:0] chan1_in_word_o,
   output reg chan1_in_valid_o,
   input wire chan1_in_ready_i,
   output reg irq_seen_o,
   output reg frame_drop_o,
   output reg serial_expander_clock_o,
   output reg chan0_load_strobe_o,
   output reg chan1_load_strobe_o,
   output reg chan0_out_data_o,
   output reg chan1_out_data_o,
   output reg expander_reset_low_o,
   input wire chan0_in_data_i,
   input wire chan1_in_data_i,
   input wire responder_irq_low_i
);
   localparam CW = 8; // Counter width
   localparam BW = 6; // Bit index width
   localparam [2:0] ST_RST = 3'h1; // Holding responder reset
   localparam [2:0] ST_SAFE = 3'h2; // Sending safe defaults
   localparam [2:0] ST_RUN = 3'h4; // Live traffic
   reg [2:0] state_ff; // One-hot link state
   reg [CW-1:0] div_ff; // Serial clock divider
   reg [BW-1:0] bit_ff; // Bit position within frame
   reg [7:0] safe_cnt_ff; // Safe frames sent
   reg [NBITS-1:0] sh0_ff; // Channel 0 outgoing shift
   reg [NBITS-1:0] sh1_ff; // Channel 1 outgoing shift
   reg [NBITS-1:0] cap0_ff; // Channel 0 incoming capture
   reg [NBITS-1:0] cap1_ff; // Channel 1 incoming capture
   reg [1:0] di0_sync_ff; // Input pin synchronisers
   reg [1:0] di1_sync_ff;
   reg [1:0] irq_sync_ff;
   wire nxt_sclk; // Serial clock level for the next cycle
   wire tick; // Half-period enable pulse
   wire rise; // Serial clock about to rise
   wire fall; // Serial clock about to fall
   wire [NBITS-1:0] live0; // Channel 0 word with alert bits
   wire [NBITS-1:0] live1;
   wire fifo0_ready;
   wire fifo1_ready;
   wire fifo0_valid;
   wire fifo1_valid;
   wire [NBITS-1:0] fifo0_data;
   wire [NBITS-1:0] fifo1_data;
   reg push_ff; // Completed frame pending push
   // Alert bits take the top two positions of channel 0
   assign live0 = {alert_sysif_i, alert_bus_i, chan0_out_word_i[NBITS-3:0]};
   assign live1 = chan1_out_word_i;
   assign tick = (div_ff == HALF[CW-1:0] - 1'b1);
   assign rise = tick & ~serial_expander_clock_o;
   assign fall = tick & serial_expander_clock_o;
   // Clock stays parked low while the responder is held in reset
   assign nxt_sclk = serial_expander_clock_o ^ (tick & (state_ff != ST_RST));
   // Divider gives the one shared serial clock for both channels
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         div_ff <= {CW{1'b0}};
         serial_expander_clock_o <= 1'b0;
      end else begin
         div_ff <= tick ? {CW{1'b0}} : div_ff + 1'b1;
         serial_expander_clock_o <= nxt_sclk;
      end
   end
   // Two-stage synchronisers on responder pins
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         di0_sync_ff <= 2'h0;
         di1_sync_ff <= 2'h0;
         irq_sync_ff <= 2'h3;
      end else begin
         di0_sync_ff <= {di0_sync_ff[0], chan0_in_data_i};
         di1_sync_ff <= {di1_sync_ff[0], chan1_in_data_i};
         irq_sync_ff <= {irq_sync_ff[0], responder_irq_low_i};
      end
   end
   // Interrupt line level, active while responder pulls low
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         irq_seen_o <= 1'b0;
      end else begin
         irq_seen_o <= ~irq_sync_ff[1];
      end
   end
   // Frame sequencer, shifting and capture
   // Input bits are sampled on our falling edge; the sync delay (2 core cycles)
   // fits inside one half period, so the responder value has settled.
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_ff <= ST_RST;
         bit_ff <= {BW{1'b0}};
         safe_cnt_ff <= 8'h00;
         sh0_ff <= SAFE0;
         sh1_ff <= SAFE1;
         cap0_ff <= {NBITS{1'b0}};
         cap1_ff <= {NBITS{1'b0}};
         chan0_out_data_o <= 1'b0;
         chan1_out_data_o <= 1'b0;
         chan0_load_strobe_o <= 1'b0;
         chan1_load_strobe_o <= 1'b0;
         expander_reset_low_o <= 1'b0;
         push_ff <= 1'b0;
      end else begin
         push_ff <= 1'b0;
         case (state_ff)
            ST_RST: begin
               // Hold responder in reset for one divider period
               if (tick) begin
                  expander_reset_low_o <= 1'b1;
                  state_ff <= ST_SAFE;
                  bit_ff <= {BW{1'b0}};
                  chan0_load_strobe_o <= 1'b1;
                  chan1_load_strobe_o <= 1'b1;
                  chan0_out_data_o <= SAFE0[NBITS-1];
                  chan1_out_data_o <= SAFE1[NBITS-1];
                  sh0_ff <= SAFE0 << 1;
                  sh1_ff <= SAFE1 << 1;
               end
            end
            ST_SAFE, ST_RUN: begin
               if (fall) begin
                  cap0_ff <= {cap0_ff[NBITS-2:0], di0_sync_ff[1]};
                  cap1_ff <= {cap1_ff[NBITS-2:0], di1_sync_ff[1]};
                  chan0_load_strobe_o <= 1'b0;
                  chan1_load_strobe_o <= 1'b0;
                  if (bit_ff == NBITS[BW-1:0] - 1'b1) begin
                     // Frame boundary: strobe, reload both channels together
                     bit_ff <= {BW{1'b0}};
                     chan0_load_strobe_o <= 1'b1;
                     chan1_load_strobe_o <= 1'b1;
                     if (state_ff == ST_RUN) begin
                        push_ff <= 1'b1;
                     end
                     if (state_ff == ST_SAFE && safe_cnt_ff < SAFE_FRAMES[7:0] - 1'b1) begin
                        safe_cnt_ff <= safe_cnt_ff + 1'b1;
                        chan0_out_data_o <= SAFE0[NBITS-1];
                        chan1_out_data_o <= SAFE1[NBITS-1];
                        sh0_ff <= SAFE0 << 1;
                        sh1_ff <= SAFE1 << 1;
                     end else begin
                        state_ff <= ST_RUN;
                        chan0_out_data_o <= live0[NBITS-1];
                        chan1_out_data_o <= live1[NBITS-1];
                        sh0_ff <= live0 << 1;
                        sh1_ff <= live1 << 1;
                     end
                  end else begin
                     // Output changes on falling edge, held across the rise
                     bit_ff <= bit_ff + 1'b1;
                     chan0_out_data_o <= sh0_ff[NBITS-1];
                     chan1_out_data_o <= sh1_ff[NBITS-1];
                     sh0_ff <= sh0_ff << 1;
                     sh1_ff <= sh1_ff << 1;
                  end
               end
            end
            default: begin
               state_ff <= ST_RST;
            end
         endcase
      end
   end
   // Received words go through FIFOs; a full FIFO drops the frame and flags it
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         frame_drop_o <= 1'b0;
      end else begin
         frame_drop_o <= push_ff & ~(fifo0_ready & fifo1_ready);
      end
   end
   sgl_fifo #(.WIDTH(NBITS), .DEPTH(`SGL_FIFO_DEPTH), .AW(`SGL_FIFO_AW)) u_fifo0 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(push_ff & fifo1_ready),
      .in_ready_o(fifo0_ready),
      .in_data_i(cap0_ff),
      .out_valid_o(fifo0_valid),
      .out_ready_i(~chan0_in_valid_o | chan0_in_ready_i), // Pop only when the output stage loads
      .out_data_o(fifo0_data)
   );
   sgl_fifo #(.WIDTH(NBITS), .DEPTH(`SGL_FIFO_DEPTH), .AW(`SGL_FIFO_AW)) u_fifo1 (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(push_ff & fifo0_ready),
      .in_ready_o(fifo1_ready),
      .in_data_i(cap1_ff),
      .out_valid_o(fifo1_valid),
      .out_ready_i(~chan1_in_valid_o | chan1_in_ready_i), // Same load rule, so no word shows twice
      .out_data_o(fifo1_data)
   );
   // Registered output stage: word shown while FIFO has data, advances on ready
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         chan0_in_valid_o <= 1'b0;
         chan1_in_valid_o <= 1'b0;
         chan0_in_word_o <= {NBITS{1'b0}};
         chan1_in_word_o <= {NBITS{1'b0}};
      end else begin
         if (!chan0_in_valid_o || chan0_in_ready_i) begin
            chan0_in_valid_o <= fifo0_valid;
            chan0_in_word_o <= fifo0_data;
         end
         if (!chan1_in_valid_o || chan1_in_ready_i) begin
            chan1_in_valid_o <= fifo1_valid;
            chan1_in_word_o <= fifo1_data;
         end
      end
   end
endmodule
